// ### shared/line_regs_pkg.sv
// Constants, types and register map for the quad line control register group.
package line_regs_pkg;

  localparam int CHANNELS = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets; the top three address bits are not decoded.
  localparam logic [4:0] ANALOG_LOOP_OFS = 5'h01;
  localparam logic [4:0] REMOTE_LOOP_OFS = 5'h02;
  localparam logic [4:0] ALL_ONES_OFS = 5'h03;
  localparam logic [4:0] LOSS_STATUS_OFS = 5'h04;
  localparam logic [4:0] FAULT_STATUS_OFS = 5'h05;
  localparam logic [4:0] LOSS_IRQ_EN_OFS = 5'h06;
  localparam logic [4:0] FAULT_IRQ_EN_OFS = 5'h07;
  localparam logic [4:0] LOSS_CHANGE_OFS = 5'h08;
  localparam logic [4:0] FAULT_CHANGE_OFS = 5'h09;
  localparam logic [4:0] SOFT_RESET_OFS = 5'h0A;
  localparam int OFS_W = 5;

  // Field layout: the per-channel bits sit in bits 3..0.
  localparam int CHAN_LSB = 0;
  localparam int CHAN_MSB = 3;

  // Reset values.
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] CHAN_RESET = 4'h0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Timing: clock period and the soft reset lengths.
  localparam int CLOCK_PERIOD_NS = 50;
  localparam int SOFT_RESET_NS = 1000;
  localparam int SOFT_RESET_LONG_NS = 2000;
  localparam int SOFT_RESET_CYCLES =
    (SOFT_RESET_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int SOFT_RESET_LONG_CYCLES =
    (SOFT_RESET_LONG_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int RESET_CNT_W = 6;

  // Synchronised pin levels: four loss, four short, five straps, host mode.
  localparam int SYNC_BITS = 2 * CHANNELS + 6;

  // One host register access, as presented by the host port logic.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } host_req_s;

  // Clocking and supply straps seen by the transmit side.
  typedef struct packed {
    logic ref_clock_present;
    logic ref_clock_high;
    logic transmit_clock_high;
    logic t1_mode;
    logic transmit_supply_3v3;
  } line_cfg_s;

  // Soft reset sequencer states.
  typedef enum logic {
    RUN,
    IN_RESET
  } reset_state_e;

endpackage

// ### hdl/pin_sync.sv
// Three-stage pin synchroniser with agreement filter, one lane per bit.
`timescale 1ns/1ps
module pin_sync
  import line_regs_pkg::*;
#(
  parameter int WIDTH = SYNC_BITS
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level
);

  //////////////////////////////////////////////////////////////////////////
  // The first stage feeds only the second; a change counts once the
  // second and third stages agree, which rejects a one-cycle glitch.
  for (genvar i = 0; i < WIDTH; i++) begin : lane
    logic first;
    logic second;
    logic third;
    wire agree = (second == third);
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        first <= 1'b0;
        second <= 1'b0;
        third <= 1'b0;
        level[i] <= 1'b0;
      end else if (ce) begin
        first <= pin_in[i];
        second <= first;
        third <= second;
        if (agree) begin
          level[i] <= third;
        end
      end
    end
  end

endmodule

// ### hdl/quad_line_control_status_regs.sv
// Control and status registers of a four-channel line transceiver.
// Notes on behaviour
// - Analog loopback bits 3..0 enable each channel's local loopback.
// - Remote loopback bits 3..0 enable each channel's remote loopback.
// - A set all-ones enable bit sends continuous marks on that channel.
// - After reset all-ones enable, loss and fault status are all zero.
// - Loss status bit follows a valid loss-of-signal detection per channel.
// - Any loss status change, either direction, raises an interrupt event.
// - One read clears every pending loss change flag at once.
// - Fault status bit follows a valid driver short circuit per channel.
// - Fault detection only works in T1 mode with a 3.3V transmit supply.
// - One read clears every pending fault change flag at once.
// - Loss interrupt forwarded only when its enable bit is one.
// - Fault interrupt forwarded only when its enable bit is one.
// - Both interrupt enable registers reset to zero.
// - All-ones timing uses the reference clock, else the transmit clock.
// - No all-ones output when reference and transmit clocks are both high.
// - Loss change flag sets when loss status changed since last clear.
// - Fault change flag sets when fault status changed since last clear.
// - Any write to soft reset register starts a 1 us reset cycle.
// - In non-multiplexed host mode the reset cycle lasts 2 us.
// - The soft reset cycle returns every register to its default.
`timescale 1ns/1ps
module quad_line_control_status_regs
  import line_regs_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire host_req_s host_req,
  input wire logic non_mux_host_mode,
  input wire logic [CHANNELS-1:0] loss_detect,
  input wire logic [CHANNELS-1:0] short_detect,
  input wire line_cfg_s line_cfg,
  output logic [DATA_W-1:0] rdata,
  output logic rdata_valid,
  output logic [CHANNELS-1:0] analog_loop_enable,
  output logic [CHANNELS-1:0] remote_loop_enable,
  output logic [CHANNELS-1:0] all_ones_transmit_enable,
  output logic [CHANNELS-1:0] all_ones_use_transmit_clock,
  output logic irq_n,
  output logic soft_reset_busy
);

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisation of the detector outputs and straps.
  logic [SYNC_BITS-1:0] sync_level;
  logic [CHANNELS-1:0] loss_level;
  logic [CHANNELS-1:0] short_level;
  line_cfg_s cfg;
  logic long_reset_mode;

  pin_sync #(.WIDTH(SYNC_BITS)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .pin_in({non_mux_host_mode, line_cfg, short_detect, loss_detect}),
    .level(sync_level)
  );

  // Unpacking of the synchronised levels, in the order of the
  // concatenation above: loss, short, straps, then host mode.
  assign loss_level = sync_level[CHANNELS-1:0];
  assign short_level = sync_level[2*CHANNELS-1:CHANNELS];
  assign cfg = sync_level[SYNC_BITS-2:2*CHANNELS];
  assign long_reset_mode = sync_level[SYNC_BITS-1];

  //////////////////////////////////////////////////////////////////////////
  // Register state.
  logic [DATA_W-1:0] analog_loop;
  logic [DATA_W-1:0] remote_loop;
  logic [DATA_W-1:0] all_ones;
  logic [DATA_W-1:0] loss_irq_en;
  logic [DATA_W-1:0] fault_irq_en;
  logic [DATA_W-1:0] soft_reset_bits;
  logic [CHANNELS-1:0] signal_loss_flag;
  logic [CHANNELS-1:0] driver_fault_flag;
  logic [CHANNELS-1:0] loss_change_flag;
  logic [CHANNELS-1:0] fault_change_flag;
  reset_state_e reset_state;
  logic [RESET_CNT_W-1:0] reset_count;

  //////////////////////////////////////////////////////////////////////////
  // Address decode. Accesses are refused while a soft reset runs, so the
  // registers stay at their defaults for the whole reset cycle.
  wire [OFS_W-1:0] ofs = host_req.addr[OFS_W-1:0];
  wire accept = (reset_state == RUN);
  wire do_wr = host_req.wr && accept;
  wire do_rd = host_req.rd && accept;
  wire wr_analog = do_wr && (ofs == ANALOG_LOOP_OFS);
  wire wr_remote = do_wr && (ofs == REMOTE_LOOP_OFS);
  wire wr_all_ones = do_wr && (ofs == ALL_ONES_OFS);
  wire wr_loss_en = do_wr && (ofs == LOSS_IRQ_EN_OFS);
  wire wr_fault_en = do_wr && (ofs == FAULT_IRQ_EN_OFS);
  wire wr_soft_reset = do_wr && (ofs == SOFT_RESET_OFS);
  wire rd_loss_change = do_rd && (ofs == LOSS_CHANGE_OFS);
  wire rd_fault_change = do_rd && (ofs == FAULT_CHANGE_OFS);

  // Soft reset length depends on the host bus mode.
  wire [RESET_CNT_W-1:0] reset_len = long_reset_mode ?
    RESET_CNT_W'(SOFT_RESET_LONG_CYCLES) : RESET_CNT_W'(SOFT_RESET_CYCLES);
  // The count is loaded with the full length and the cycle ends when it
  // reaches one, so the reset lasts exactly that many enabled clocks.
  wire reset_done = (reset_count == RESET_CNT_W'(1));
  wire regs_clear = !rst_n || (reset_state == IN_RESET);

  //////////////////////////////////////////////////////////////////////////
  // Soft reset sequencer: counts the reset length down, then releases.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reset_state <= RUN;
      reset_count <= '0;
    end else if (ce) begin
      case (reset_state)
        RUN: begin
          if (wr_soft_reset) begin
            reset_state <= IN_RESET;
            reset_count <= reset_len;
          end
        end
        IN_RESET: begin
          reset_count <= reset_count - RESET_CNT_W'(1);
          if (reset_done) begin
            reset_state <= RUN;
          end
        end
        default: begin
          reset_state <= RUN;
          reset_count <= '0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Writable registers. All eight bits are stored so the host reads back
  // what it wrote, except soft_reset_bits, which is never written and reads zero; only bits 3..0 steer the channels.
  always_ff @(posedge clock) begin
    if (regs_clear) begin
      analog_loop <= REG_RESET;
      remote_loop <= REG_RESET;
      all_ones <= REG_RESET;
      loss_irq_en <= REG_RESET;
      fault_irq_en <= REG_RESET;
      soft_reset_bits <= REG_RESET;
    end else if (ce) begin
      if (wr_analog) begin
        analog_loop <= host_req.wdata;
      end
      if (wr_remote) begin
        remote_loop <= host_req.wdata;
      end
      if (wr_all_ones) begin
        all_ones <= host_req.wdata;
      end
      if (wr_loss_en) begin
        loss_irq_en <= host_req.wdata;
      end
      if (wr_fault_en) begin
        fault_irq_en <= host_req.wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Status and change flags. A change seen in the cycle of the clearing
  // read wins over the clear, so no transition is ever lost.
  wire fault_allowed = cfg.t1_mode && cfg.transmit_supply_3v3;
  wire [CHANNELS-1:0] next_loss = loss_level;
  wire [CHANNELS-1:0] next_fault = short_level & {CHANNELS{fault_allowed}};
  wire [CHANNELS-1:0] loss_edge = next_loss ^ signal_loss_flag;
  wire [CHANNELS-1:0] fault_edge = next_fault ^ driver_fault_flag;
  wire [CHANNELS-1:0] next_loss_change =
    (rd_loss_change ? CHAN_RESET : loss_change_flag) | loss_edge;
  wire [CHANNELS-1:0] next_fault_change =
    (rd_fault_change ? CHAN_RESET : fault_change_flag) | fault_edge;

  always_ff @(posedge clock) begin
    if (regs_clear) begin
      signal_loss_flag <= CHAN_RESET;
      driver_fault_flag <= CHAN_RESET;
      loss_change_flag <= CHAN_RESET;
      fault_change_flag <= CHAN_RESET;
    end else if (ce) begin
      signal_loss_flag <= next_loss;
      driver_fault_flag <= next_fault;
      loss_change_flag <= next_loss_change;
      fault_change_flag <= next_fault_change;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data multiplexer; unmapped offsets read as zero.
  // Reading has no side effect here; the change flags clear in their own
  // process, where a new event can still win over the clear.
  logic [DATA_W-1:0] read_mux;
  always_comb begin
    case (ofs)
      ANALOG_LOOP_OFS: read_mux = analog_loop;
      REMOTE_LOOP_OFS: read_mux = remote_loop;
      ALL_ONES_OFS: read_mux = all_ones;
      LOSS_STATUS_OFS: read_mux = {4'h0, signal_loss_flag};
      FAULT_STATUS_OFS: read_mux = {4'h0, driver_fault_flag};
      LOSS_IRQ_EN_OFS: read_mux = loss_irq_en;
      FAULT_IRQ_EN_OFS: read_mux = fault_irq_en;
      LOSS_CHANGE_OFS: read_mux = {4'h0, loss_change_flag};
      FAULT_CHANGE_OFS: read_mux = {4'h0, fault_change_flag};
      SOFT_RESET_OFS: read_mux = soft_reset_bits;
      default: read_mux = UNMAPPED_READ;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Channel controls. All-ones output is dropped in data recovery and
  // line driver mode, where there is no clock to time the marks with.
  // Only the choice of timing reference is reported; the marks themselves
  // are made in the transmit path.
  wire driver_mode = cfg.ref_clock_high && cfg.transmit_clock_high;
  wire [CHANNELS-1:0] next_all_ones =
    all_ones[CHAN_MSB:CHAN_LSB] & {CHANNELS{!driver_mode}};
  wire [CHANNELS-1:0] next_use_transmit_clock =
    next_all_ones & {CHANNELS{!cfg.ref_clock_present}};
  wire loss_irq = |(loss_change_flag & loss_irq_en[CHAN_MSB:CHAN_LSB]);
  wire fault_irq = |(fault_change_flag & fault_irq_en[CHAN_MSB:CHAN_LSB]);

  // Registered outputs; the interrupt lags its flags by one cycle.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata <= REG_RESET;
      rdata_valid <= 1'b0;
      analog_loop_enable <= CHAN_RESET;
      remote_loop_enable <= CHAN_RESET;
      all_ones_transmit_enable <= CHAN_RESET;
      all_ones_use_transmit_clock <= CHAN_RESET;
      irq_n <= 1'b1;
      soft_reset_busy <= 1'b0;
    end else if (ce) begin
      rdata <= do_rd ? read_mux : REG_RESET;
      rdata_valid <= do_rd;
      analog_loop_enable <= analog_loop[CHAN_MSB:CHAN_LSB];
      remote_loop_enable <= remote_loop[CHAN_MSB:CHAN_LSB];
      all_ones_transmit_enable <= next_all_ones;
      all_ones_use_transmit_clock <= next_use_transmit_clock;
      irq_n <= !(loss_irq || fault_irq);
      soft_reset_busy <= (reset_state == IN_RESET);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks on the register behaviour.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  analog_loop_out_a: assert property (
    ce && $past(ce) && !$past(regs_clear) |->
      analog_loop_enable == $past(analog_loop[CHAN_MSB:CHAN_LSB]))
    else $error("Analog loopback output does not follow its register.");
  remote_loop_out_a: assert property (
    wr_remote && ce ##1 ce && accept |=>
      remote_loop_enable == $past(host_req.wdata[CHAN_MSB:CHAN_LSB], 2))
    else $error("Remote loopback output missed a write.");
  all_ones_mode_a: assert property (
    ce && $past(ce) && $past(driver_mode) |->
      all_ones_transmit_enable == CHAN_RESET)
    else $error("All-ones sent in line driver mode.");
  loss_status_a: assert property (
    ce && accept && !wr_soft_reset |=> signal_loss_flag == $past(loss_level))
    else $error("Loss status does not track the detector.");
  fault_gate_a: assert property (
    !fault_allowed && ce |=> driver_fault_flag == CHAN_RESET)
    else $error("Fault reported outside T1 3.3V mode.");
  loss_change_set_a: assert property (
    ce && accept && !wr_soft_reset && (loss_edge != CHAN_RESET) |=>
      (loss_change_flag & $past(loss_edge)) == $past(loss_edge))
    else $error("Loss change flag missed a status change.");
  loss_read_clear_a: assert property (
    rd_loss_change && ce && loss_edge == CHAN_RESET |=>
      loss_change_flag == CHAN_RESET)
    else $error("Loss change flags not cleared by a read.");
  fault_read_clear_a: assert property (
    rd_fault_change && ce && fault_edge == CHAN_RESET |=>
      fault_change_flag == CHAN_RESET)
    else $error("Fault change flags not cleared by a read.");
  irq_out_a: assert property (
    ce && $past(ce) |-> irq_n == !$past(loss_irq || fault_irq))
    else $error("Interrupt output does not match enabled flags.");
  short_reset_a: assert property (
    wr_soft_reset && ce && !long_reset_mode && $past(ce) [*1] |=>
      (reset_state == IN_RESET && reset_count == RESET_CNT_W'(20)))
    else $error("Soft reset did not load a 1 us length.");
  long_reset_a: assert property (
    wr_soft_reset && ce && long_reset_mode |=>
      reset_count == RESET_CNT_W'(40))
    else $error("Soft reset did not load a 2 us length.");
  reset_defaults_a: assert property (
    reset_state == IN_RESET && ce |=>
      all_ones == REG_RESET && loss_irq_en == REG_RESET &&
      fault_irq_en == REG_RESET && analog_loop == REG_RESET)
    else $error("Registers not at default during soft reset.");

  // Channel outputs, interrupt masking and read answers.
  all_ones_out_a: assert property (
    ce && $past(ce) && !$past(driver_mode) |->
      all_ones_transmit_enable == $past(all_ones[CHAN_MSB:CHAN_LSB]))
    else $error("All-ones output does not follow its register.");
  ref_clock_sel_a: assert property (
    ce && $past(ce) && $past(cfg.ref_clock_present) |->
      all_ones_use_transmit_clock == CHAN_RESET)
    else $error("Transmit clock used while the reference clock runs.");
  irq_masked_a: assert property (
    ce && $past(ce) && $past(loss_irq_en[CHAN_MSB:CHAN_LSB] == CHAN_RESET) &&
      $past(fault_irq_en[CHAN_MSB:CHAN_LSB] == CHAN_RESET) |-> irq_n)
    else $error("Interrupt raised with every channel disabled.");
  busy_refuse_a: assert property (
    ce && reset_state == IN_RESET && host_req.rd |=> !rdata_valid)
    else $error("Read answered during a soft reset.");
  change_read_a: assert property (
    rd_loss_change && ce |=>
      rdata_valid && rdata == {4'h0, $past(loss_change_flag)})
    else $error("Loss change read returned the wrong flags.");

  // Fault status, sticky change flags and soft reset defaults.
  fault_status_a: assert property (
    ce && accept && !wr_soft_reset && fault_allowed |=>
      driver_fault_flag == $past(short_level))
    else $error("Fault status does not track the short monitor.");
  fault_change_set_a: assert property (
    ce && accept && !wr_soft_reset && (fault_edge != CHAN_RESET) |=>
      (fault_change_flag & $past(fault_edge)) == $past(fault_edge))
    else $error("Fault change flag missed a status change.");
  loss_change_hold_a: assert property (
    ce && accept && !rd_loss_change && !wr_soft_reset |=>
      (loss_change_flag & $past(loss_change_flag)) == $past(loss_change_flag))
    else $error("Loss change flag dropped without a clearing read.");
  fault_change_hold_a: assert property (
    ce && accept && !rd_fault_change && !wr_soft_reset |=>
      (fault_change_flag & $past(fault_change_flag)) ==
        $past(fault_change_flag))
    else $error("Fault change flag dropped without a clearing read.");
  status_defaults_a: assert property (
    reset_state == IN_RESET |=> signal_loss_flag == CHAN_RESET &&
      driver_fault_flag == CHAN_RESET && all_ones == REG_RESET)
    else $error("Status not at default during soft reset.");
  enable_defaults_a: assert property (
    reset_state == IN_RESET |=> loss_irq_en == REG_RESET &&
      fault_irq_en == REG_RESET && remote_loop == REG_RESET)
    else $error("Interrupt enables not cleared by the soft reset.");

endmodule

// ### dv/host_model.sv
// Host processor model that issues register accesses on the host port.
`timescale 1ns/1ps
module host_model
  import line_regs_pkg::*;
(
  input wire logic clock,
  output host_req_s host_req
);
  // Expected read data, oldest first; the bench's monitor takes from here.
  logic [DATA_W-1:0] exp_q[$];

  ////////////////////////////////////////////////////////////////////////////
  // One request per call, launched at the falling edge and held until the
  // next one, so back-to-back calls never touch the port twice in a step.
  task automatic access(input logic w, input logic r, input logic [7:0] a,
                        input logic [7:0] d, input logic [7:0] exp,
                        input logic note);
    logic [7:0] wd;
    wd = d;
    if (a[4:0] inside {ALL_ONES_OFS, LOSS_IRQ_EN_OFS, FAULT_IRQ_EN_OFS}) begin
      wd[7:4] = 4'h0;
    end
    @(negedge clock);
    // The top address bits are random, as the port decodes only five.
    host_req <= '{wr: w, rd: r, addr: {3'($urandom), a[4:0]}, wdata: wd};
    if (r && note) begin
      exp_q.push_back(exp);
    end
  endtask

  // Idle cycles; the caller gives the count, one no-access request per clock.
  task automatic idle(input int n);
    repeat (n) access(1'b0, 1'b0, 8'h00, 8'h00, 8'h00, 1'b0);
  endtask

  // The port starts idle so nothing is requested during reset.
  initial begin
    host_req = '0;
  end
endmodule

// ### dv/tb_top.sv
// Self-checking bench for the quad line control and status registers.
`timescale 1ns/1ps
module tb_top
  import line_regs_pkg::*;
;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic non_mux_host_mode = 1'b0;
  logic [CHANNELS-1:0] loss_detect = '0;
  logic [CHANNELS-1:0] short_detect = '0;
  line_cfg_s line_cfg = '0;
  host_req_s host_req;
  logic [DATA_W-1:0] rdata;
  logic rdata_valid, irq_n, soft_reset_busy;
  logic [CHANNELS-1:0] analog_loop_enable, remote_loop_enable;
  logic [CHANNELS-1:0] all_ones_transmit_enable, all_ones_use_transmit_clock;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [3:0] v, v2, hi;
  int cnt;

  ////////////////////////////////////////////////////////////////////////////
  host_model host_u (.clock(clock), .host_req(host_req));

  quad_line_control_status_regs dut_u (
    .clock(clock), .rst_n(rst_n), .ce(ce), .host_req(host_req),
    .non_mux_host_mode(non_mux_host_mode), .loss_detect(loss_detect),
    .short_detect(short_detect), .line_cfg(line_cfg), .rdata(rdata),
    .rdata_valid(rdata_valid), .analog_loop_enable(analog_loop_enable),
    .remote_loop_enable(remote_loop_enable),
    .all_ones_transmit_enable(all_ones_transmit_enable),
    .all_ones_use_transmit_clock(all_ones_use_transmit_clock),
    .irq_n(irq_n), .soft_reset_busy(soft_reset_busy));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.access(1'b1, 1'b0, a, d, 8'h00, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host_u.access(1'b0, 1'b1, a, 8'h00, e, 1'b1);
  endtask

  // Starts a soft reset, tries reads that must be refused, counts busy.
  task automatic soft_reset(input int span, output int n);
    wr(8'h0A, 8'h0F);
    n = 0;
    for (int k = 0; k < span; k++) begin
      host_u.access(1'b0, k < 5, 8'h01, 8'h00, 8'h00, 1'b0);
      if (soft_reset_busy === 1'b1) begin
        n++;
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Clock, and a cycle ceiling far above the few hundred cycles needed.
  initial begin
    forever #25 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // Every answered read is matched against the oldest noted expectation.
  always @(negedge clock) begin
    if (rdata_valid === 1'b1) begin
      if (host_u.exp_q.size() == 0) begin
        num_errors++;
        $display("ERROR rdata expected none seen %h", rdata);
      end else begin
        check("rdata", host_u.exp_q.pop_front(), rdata);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    line_cfg.ref_clock_present = 1'b1;
    void'($urandom(32'h2FAF8117));
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    check("irq_n", 8'h01, {7'h00, irq_n});
    for (int a = 3; a <= 9; a++) rd(a[7:0], REG_RESET);
    rd(8'h1F, UNMAPPED_READ);
    wr(8'h04, 8'h0F);
    rd(8'h04, 8'h00);
    // Loopback enables reach the channel outputs and read back.
    v = 4'($urandom_range(15, 1));
    v2 = 4'($urandom_range(15, 1));
    hi = 4'($urandom);
    wr(8'h01, {hi, v});
    wr(8'h02, {hi, v2});
    rd(8'h01, {hi, v});
    rd(8'h02, {hi, v2});
    host_u.idle(2);
    check("analog_loop", {4'h0, v}, {4'h0, analog_loop_enable});
    check("remote_loop", {4'h0, v2}, {4'h0, remote_loop_enable});
    // Clock enable low freezes every register, so this write leaves no trace.
    ce = 1'b0;
    wr(8'h01, {hi, ~v});
    host_u.idle(3);
    ce = 1'b1;
    check("analog_frozen", {4'h0, v}, {4'h0, analog_loop_enable});
    rd(8'h01, {hi, v});
    // All-ones transmit, its timing reference and the driver-mode block.
    wr(8'h03, 8'h0F);
    host_u.idle(3);
    check("all_ones", 8'h0F, {4'h0, all_ones_transmit_enable});
    check("use_transmit_clock", 8'h00, {4'h0, all_ones_use_transmit_clock});
    line_cfg.ref_clock_present = 1'b0;
    host_u.idle(6);
    check("use_transmit_clock", 8'h0F, {4'h0, all_ones_use_transmit_clock});
    line_cfg.ref_clock_high = 1'b1;
    line_cfg.transmit_clock_high = 1'b1;
    host_u.idle(6);
    check("all_ones", 8'h00, {4'h0, all_ones_transmit_enable});
    rd(8'h03, 8'h0F);
    // Random clock straps; the fault straps stay low until their scenario.
    line_cfg = 5'($urandom) & 5'h1C;
    // Loss events: both directions, clear on read, masking.
    wr(8'h06, 8'h0F);
    v = 4'($urandom_range(15, 1));
    loss_detect = v;
    host_u.idle(6);
    check("irq_n", 8'h00, {7'h00, irq_n});
    v2 = line_cfg.ref_clock_high && line_cfg.transmit_clock_high ?
      4'h0 : 4'hF;
    check("all_ones", {4'h0, v2}, {4'h0, all_ones_transmit_enable});
    rd(8'h04, {4'h0, v});
    rd(8'h08, {4'h0, v});
    rd(8'h08, 8'h00);
    host_u.idle(2);
    check("irq_n", 8'h01, {7'h00, irq_n});
    loss_detect = '0;
    host_u.idle(6);
    check("irq_n", 8'h00, {7'h00, irq_n});
    rd(8'h08, {4'h0, v});
    wr(8'h06, {4'h0, ~v});
    loss_detect = v;
    host_u.idle(6);
    check("irq_n", 8'h01, {7'h00, irq_n});
    rd(8'h08, {4'h0, v});
    // Driver faults only count in T1 with the 3.3V supply.
    wr(8'h07, 8'h0F);
    line_cfg.transmit_supply_3v3 = 1'b1;
    short_detect = v;
    host_u.idle(6);
    rd(8'h05, 8'h00);
    rd(8'h09, 8'h00);
    line_cfg.t1_mode = 1'b1;
    host_u.idle(6);
    check("irq_n", 8'h00, {7'h00, irq_n});
    rd(8'h05, {4'h0, v});
    rd(8'h09, {4'h0, v});
    rd(8'h09, 8'h00);
    host_u.idle(2);
    check("irq_n", 8'h01, {7'h00, irq_n});
    // Quiet the pins, then time both soft reset lengths.
    loss_detect = '0;
    short_detect = '0;
    host_u.idle(6);
    rd(8'h08, {4'h0, v});
    rd(8'h09, {4'h0, v});
    wr(8'h01, 8'h05);
    soft_reset(60, cnt);
    check("busy_len", 8'(SOFT_RESET_CYCLES), 8'(cnt));
    rd(8'h01, REG_RESET);
    rd(8'h03, REG_RESET);
    rd(8'h06, REG_RESET);
    rd(8'h07, REG_RESET);
    non_mux_host_mode = 1'b1;
    host_u.idle(6);
    soft_reset(80, cnt);
    check("busy_len", 8'(SOFT_RESET_LONG_CYCLES), 8'(cnt));
    rd(8'h02, REG_RESET);
    host_u.idle(4);
    check("pending", 8'h00, 8'(host_u.exp_q.size()));
    tally_and_finish();
  end
endmodule
